/* File: rtl/asf_pkg.sv */
// Constants, types and decode functions of the converter sequencer and result FIFO
package asf_pkg;

    // ----------------------------------------------------------------
    // Commands and configuration layout
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_CFG_WRITE = 4'hA;
    localparam logic [3:0] CMD_FIFO_READ = 4'hE;
    localparam int CFG_THR_LSB = 0;
    localparam int CFG_SWEEP_LSB = 3;
    localparam int CFG_MODE_LSB = 5;
    localparam int CFG_INT_CLK_BIT = 7;
    localparam int CFG_LONG_BIT = 8;
    localparam int CFG_PIN_TRIG_BIT = 9;
    localparam logic [11:0] CFG_RESET = 12'h000;

    // ----------------------------------------------------------------
    // Frame and timing
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CMD_BITS = 4;
    localparam logic [5:0] SAMPLE_SHORT_BITS = 6'h10;
    localparam logic [5:0] SAMPLE_LONG_BITS = 6'h30;
    localparam int CONV_CLKS_14 = 18;
    localparam int CONV_CLKS_12 = 13;
    localparam int CONV_EXTRA_NS = 15;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_EXTRA_CYC_RAW = (CONV_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_EXTRA_CYC = (CONV_EXTRA_CYC_RAW < 1) ? 1 : CONV_EXTRA_CYC_RAW;
    localparam logic [1:0] SCLK_PER_CCLK_M1 = 2'h3;
    localparam int OSC_DIV_DEF = 6;

    // ----------------------------------------------------------------
    // FIFO and thresholds
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] THR_FULL = 4'h8;
    localparam logic [3:0] THR_3Q = 4'h6;
    localparam logic [3:0] THR_HALF = 4'h4;
    localparam logic [3:0] THR_1Q = 4'h2;

    typedef enum logic [1:0] {MODE_SHOT, MODE_REPEAT, MODE_SWEEP, MODE_RSWEEP} asf_mode_t;

    function automatic logic [3:0] asf_thr_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: asf_thr_level = THR_FULL;
            2'h1: asf_thr_level = THR_3Q;
            2'h2: asf_thr_level = THR_HALF;
            2'h3: asf_thr_level = THR_1Q;
        endcase
    endfunction

    function automatic logic [2:0] asf_seq_chan(input logic [1:0] sel, input logic [2:0] pos);
        unique case (sel)
            2'h0: asf_seq_chan = pos;
            2'h1: asf_seq_chan = {pos[1:0], 1'b0};
            2'h2: asf_seq_chan = {pos[2:1], 1'b0};
            2'h3: asf_seq_chan = {1'b0, pos[0], 1'b0};
        endcase
    endfunction

endpackage

/* File: rtl/asf_result_fifo.sv */
// Result FIFO with valid/ready on both sides and a fill threshold compare
module asf_result_fifo import asf_pkg::*; #(
    parameter int W = 14,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    input wire logic [3:0] threshold,
    output logic [3:0] count,
    output logic thr_hit
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [3:0] cnt;
    } asf_fifo_st_t;

    asf_fifo_st_t s_reg, s_next;
    logic do_wr, do_rd;

    assign in_ready = (s_reg.cnt != 4'(DEPTH));
    assign out_valid = (s_reg.cnt != 4'h0);
    assign out_data = s_reg.mem[s_reg.rp];
    assign count = s_reg.cnt;
    assign thr_hit = (s_reg.cnt >= threshold);

    always_comb begin
        s_next = s_reg;
        do_wr = in_valid && in_ready;
        do_rd = out_ready && out_valid;
        if (clear) begin
            s_next.wp = '0;
            s_next.rp = '0;
            s_next.cnt = 4'h0;
        end else begin
            if (do_wr) begin
                s_next.mem[s_reg.wp] = in_data;
                s_next.wp = AW'(s_reg.wp + 1'b1);
            end
            if (do_rd) begin
                s_next.rp = AW'(s_reg.rp + 1'b1);
            end
            s_next.cnt = 4'(s_reg.cnt + {3'h0, do_wr} - {3'h0, do_rd});
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

/* File: rtl/asf_seq_ctrl.sv */
// Converter sequencer: serial frame decode, conversion timing, modes and FIFO control
module asf_seq_ctrl import asf_pkg::*; #(
    parameter int RES_BITS = 14,
    parameter int OSC_DIV = OSC_DIV_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cs_n_pin,
    input wire logic frame_sync,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic conv_start_pin_n,
    input wire logic [RES_BITS-1:0] adc_result,
    output logic sdo,
    output logic sdo_oe,
    output logic eoc,
    output logic int_n,
    output logic [2:0] channel,
    output logic power_down
);
    localparam int CONV_CLKS = (RES_BITS == 14) ? CONV_CLKS_14 : CONV_CLKS_12;

    typedef enum logic {FR_IDLE, FR_ACTIVE} asf_frame_t;
    typedef enum logic [1:0] {CV_IDLE, CV_RUN, CV_EXTRA, CV_PUSH} asf_conv_t;

    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] fs_s;
        logic [2:0] sclk_s;
        logic [1:0] sdi_s;
        logic [2:0] cst_s;
        asf_frame_t fst;
        logic [5:0] bitcnt;
        logic [15:0] in_sr;
        logic [15:0] out_sr;
        logic sdo_oe;
        logic fifo_frame;
        logic [3:0] cmd;
        logic sel_pend;
        logic [11:0] cfg;
        asf_conv_t cst;
        logic [4:0] ccnt;
        logic [1:0] div4;
        logic [7:0] osc_cnt;
        logic [3:0] xcnt;
        logic [RES_BITS-1:0] result;
        logic [RES_BITS-1:0] push_data;
        logic eoc;
        logic int_n;
        logic pd;
        logic run_active;
        logic armed;
        logic int_seen;
        logic reading;
        logic [2:0] chan;
        logic [2:0] pos;
    } asf_state_t;

    asf_state_t s_reg, s_next;

    logic fifo_clear, fifo_pop, fifo_in_ready, fifo_valid, fifo_thr_hit;
    logic [RES_BITS-1:0] fifo_data;
    logic [3:0] fifo_count;
    logic cs_fall, cs_rise, fs_rise, sclk_rise, sclk_fall, cst_fall, cst_rise;
    logic start, new_run, tick, new_run_ok, pin_trig;
    logic [3:0] cmd_now;
    logic [11:0] data_now;
    asf_mode_t mode;

    // Result aligned to the top of the 16-bit output frame
    function automatic logic [15:0] frame_word(input logic [RES_BITS-1:0] r);
        frame_word = {r, {(FRAME_BITS - RES_BITS){1'b0}}};
    endfunction

    asf_result_fifo #(.W(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .clear(fifo_clear),
        .in_valid(s_reg.cst == CV_PUSH),
        .in_data(s_reg.push_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop),
        .threshold(asf_thr_level(s_reg.cfg[CFG_THR_LSB +: 2])),
        .count(fifo_count),
        .thr_hit(fifo_thr_hit)
    );

    assign sdo = s_reg.out_sr[15];
    assign sdo_oe = s_reg.sdo_oe;
    assign eoc = s_reg.eoc;
    assign int_n = s_reg.int_n;
    assign channel = s_reg.chan;
    assign power_down = s_reg.pd;

    always_comb begin
        s_next = s_reg;
        fifo_clear = 1'b0;
        fifo_pop = 1'b0;
        start = 1'b0;
        new_run = 1'b0;
        tick = 1'b0;
        cmd_now = {s_reg.in_sr[2:0], s_reg.sdi_s[1]};
        data_now = {s_reg.in_sr[10:0], s_reg.sdi_s[1]};
        mode = asf_mode_t'(s_reg.cfg[CFG_MODE_LSB +: 2]);
        pin_trig = s_reg.cfg[CFG_PIN_TRIG_BIT];
        // Mode 10 must be drained, partly read or reconfigured first; 01 and 11 overwrite
        new_run_ok = s_reg.cfg[CFG_MODE_LSB] || !fifo_valid;

        // --------------------------------------------------------
        // Pin synchronisers; edges come from the second and third stages, sdi from the second
        // --------------------------------------------------------
        s_next.cs_s = {s_reg.cs_s[1:0], cs_n_pin};
        s_next.fs_s = {s_reg.fs_s[1:0], frame_sync};
        s_next.sclk_s = {s_reg.sclk_s[1:0], sclk_pin};
        s_next.sdi_s = {s_reg.sdi_s[0], sdi_pin};
        s_next.cst_s = {s_reg.cst_s[1:0], conv_start_pin_n};
        cs_fall = !s_reg.cs_s[1] && s_reg.cs_s[2];
        cs_rise = s_reg.cs_s[1] && !s_reg.cs_s[2];
        fs_rise = s_reg.fs_s[1] && !s_reg.fs_s[2];
        sclk_rise = s_reg.sclk_s[1] && !s_reg.sclk_s[2];
        sclk_fall = !s_reg.sclk_s[1] && s_reg.sclk_s[2];
        cst_fall = !s_reg.cst_s[1] && s_reg.cst_s[2];
        cst_rise = s_reg.cst_s[1] && !s_reg.cst_s[2];

        // --------------------------------------------------------
        // Frame start, wake-up and early FIFO output
        // --------------------------------------------------------
        if (cs_fall || fs_rise) begin
            s_next.fst = FR_ACTIVE;
            s_next.bitcnt = 6'h00;
            s_next.sel_pend = 1'b0;
            s_next.pd = 1'b0;
            s_next.int_n = 1'b1;
            s_next.sdo_oe = 1'b1;
            s_next.int_seen = 1'b0;
            // Head goes out before the command is known
            s_next.fifo_frame = (s_reg.int_seen || s_reg.reading) && fifo_valid;
            s_next.out_sr = s_next.fifo_frame ? frame_word(fifo_data) : frame_word(s_reg.result);
        end else if (cs_rise && s_reg.fst == FR_ACTIVE) begin
            s_next.fst = FR_IDLE;
            s_next.sdo_oe = 1'b0;
            s_next.sel_pend = 1'b0;
        end else if (s_reg.fst == FR_ACTIVE) begin
            if (sclk_rise && s_reg.bitcnt != 6'h00) begin
                s_next.out_sr = {s_reg.out_sr[14:0], 1'b0};
            end
            if (sclk_fall) begin
                s_next.in_sr = {s_reg.in_sr[14:0], s_reg.sdi_s[1]};
                if (s_reg.bitcnt != 6'h3F) begin
                    s_next.bitcnt = 6'(s_reg.bitcnt + 1'b1);
                end
                if (s_reg.bitcnt == 6'(CMD_BITS - 1)) begin
                    s_next.cmd = cmd_now;
                    if (s_reg.fifo_frame && cmd_now != CMD_FIFO_READ) begin
                        s_next.sdo_oe = 1'b0;
                    end
                    if (s_reg.reading && cmd_now != CMD_FIFO_READ) begin
                        fifo_clear = 1'b1;
                        s_next.reading = 1'b0;
                    end
                end
                if (s_reg.bitcnt == 6'(FRAME_BITS - 1)) begin
                    if (s_reg.cmd == CMD_CFG_WRITE) begin
                        // No conversion, eoc and int_n untouched
                        s_next.cfg = data_now;
                        fifo_clear = 1'b1;
                        s_next.run_active = 1'b0;
                        s_next.armed = 1'b0;
                        s_next.reading = 1'b0;
                    end else if (s_reg.cmd == CMD_FIFO_READ) begin
                        // Pops one entry; no conversion is started
                        fifo_pop = fifo_valid;
                        s_next.reading = fifo_count > 4'h1;
                        if (fifo_count <= 4'h1 && mode[1]) begin
                            s_next.armed = 1'b0;
                        end
                    end else if (!s_reg.cmd[3]) begin
                        // Select: a dummy code once a run is under way
                        if (mode == MODE_SHOT) begin
                            s_next.chan = s_reg.cmd[2:0];
                        end else if (!s_reg.run_active && new_run_ok) begin
                            new_run = 1'b1;
                            if (mode == MODE_REPEAT) begin
                                s_next.chan = s_reg.cmd[2:0];
                            end
                        end
                        if (mode == MODE_SHOT || s_reg.run_active || new_run_ok) begin
                            if (pin_trig) begin
                                s_next.armed = 1'b1;
                            end else begin
                                s_next.sel_pend = 1'b1;
                            end
                        end
                    end
                end
                // Sampling ends after the 16th or 48th falling edge
                if (s_next.sel_pend && s_next.bitcnt ==
                    (s_reg.cfg[CFG_LONG_BIT] ? SAMPLE_LONG_BITS : SAMPLE_SHORT_BITS)) begin
                    s_next.sel_pend = 1'b0;
                    start = 1'b1;
                end
            end
        end

        // --------------------------------------------------------
        // Start pin: wake on assertion, convert on release
        // --------------------------------------------------------
        if (cst_fall) begin
            s_next.pd = 1'b0;
        end
        if (cst_rise && pin_trig && s_reg.armed && s_reg.cst == CV_IDLE) begin
            if (mode == MODE_SHOT || s_reg.run_active) begin
                start = 1'b1;
            end else if (mode == MODE_REPEAT || mode == MODE_RSWEEP || !fifo_valid) begin
                new_run = 1'b1;
                start = 1'b1;
            end
        end

        if (new_run) begin
            fifo_clear = 1'b1;
            s_next.run_active = 1'b1;
            s_next.reading = 1'b0;
            s_next.pos = 3'h0;
        end

        // --------------------------------------------------------
        // Conversion engine
        // --------------------------------------------------------
        s_next.osc_cnt = (s_reg.osc_cnt == 8'(OSC_DIV - 1)) ? 8'h00 : 8'(s_reg.osc_cnt + 1'b1);
        if (start && s_reg.cst == CV_IDLE) begin
            s_next.cst = CV_RUN;
            s_next.eoc = 1'b0;
            s_next.pd = 1'b0;
            s_next.ccnt = 5'h00;
            s_next.div4 = 2'h0;
            if (mode[1]) begin
                s_next.chan = asf_seq_chan(s_reg.cfg[CFG_SWEEP_LSB +: 2], new_run ? 3'h0 : s_reg.pos);
                s_next.pos = 3'(s_next.pos + 1'b1);
            end
        end
        unique case (s_reg.cst)
            CV_IDLE: begin
            end
            CV_RUN: begin
                if (s_reg.cfg[CFG_INT_CLK_BIT]) begin
                    tick = (s_reg.osc_cnt == 8'(OSC_DIV - 1));
                end else if (sclk_rise) begin
                    s_next.div4 = 2'(s_reg.div4 + 1'b1);
                    tick = (s_reg.div4 == SCLK_PER_CCLK_M1);
                end
                if (tick) begin
                    s_next.ccnt = 5'(s_reg.ccnt + 1'b1);
                    if (s_reg.ccnt == 5'(CONV_CLKS - 1)) begin
                        s_next.cst = CV_EXTRA;
                        s_next.xcnt = 4'h0;
                    end
                end
            end
            CV_EXTRA: begin
                s_next.xcnt = 4'(s_reg.xcnt + 1'b1);
                if (s_reg.xcnt == 4'(CONV_EXTRA_CYC - 1)) begin
                    s_next.eoc = 1'b1;
                    s_next.pd = 1'b1;
                    if (mode == MODE_SHOT) begin
                        // Overwrites an unread result
                        s_next.result = adc_result;
                        s_next.int_n = 1'b0;
                        s_next.cst = CV_IDLE;
                    end else begin
                        s_next.push_data = adc_result;
                        s_next.cst = CV_PUSH;
                    end
                end
            end
            CV_PUSH: begin
                // Waits here while the FIFO is full, so no result is lost
                if (fifo_in_ready) begin
                    s_next.cst = CV_IDLE;
                end
            end
        endcase

        // Threshold check once the last push has landed
        if (s_reg.cst == CV_IDLE && s_reg.run_active && !new_run && fifo_thr_hit) begin
            s_next.run_active = 1'b0;
            s_next.int_n = 1'b0;
            s_next.int_seen = 1'b1;
            if (mode == MODE_SWEEP) begin
                s_next.armed = 1'b0;
            end
        end

        // Sequence position does not survive power-down between runs
        if (s_reg.pd && !s_reg.run_active) begin
            s_next.pos = 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.cs_s <= 3'h7;
            s_reg.fs_s <= 3'h0;
            s_reg.cst_s <= 3'h7;
            s_reg.cfg <= CFG_RESET;
            s_reg.fst <= FR_IDLE;
            s_reg.cst <= CV_IDLE;
            s_reg.eoc <= 1'b1;
            s_reg.int_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

/* File: bench/asf_seq_ctrl_sva.sv */
// Port-level checker for the converter sequencer
module asf_seq_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cs_n_pin,
    input wire logic sdo_oe,
    input wire logic eoc,
    input wire logic int_n,
    input wire logic [2:0] channel,
    input wire logic power_down
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    chk_reset_idle_vals: assert property (
        $rose(rstn) |-> eoc && int_n && !sdo_oe && !power_down && channel == 3'h0) else $error("bad idle after reset");
    chk_pd_at_end: assert property (
        $rose(eoc) |-> power_down) else $error("no power-down at conversion end");
    chk_pd_cause: assert property (
        $rose(power_down) |-> $rose(eoc)) else $error("power-down without conversion end");
    chk_wake_on_select: assert property (
        power_down && $fell(cs_n_pin) |-> ##[1:8] !power_down) else $error("select did not wake");
    chk_conv_min_len: assert property (
        $fell(eoc) |-> !eoc [*8]) else $error("conversion too short");
    chk_int_at_end: assert property (
        $fell(int_n) |-> eoc) else $error("interrupt during conversion");
    chk_int_release: assert property (
        !int_n && $fell(cs_n_pin) |-> ##[1:8] int_n) else $error("interrupt not released");
    chk_oe_idle_off: assert property (
        cs_n_pin [*6] |-> !sdo_oe) else $error("output driven while deselected");
    chk_oe_frame_on: assert property (
        $fell(cs_n_pin) |-> ##[2:6] sdo_oe) else $error("output not driven in frame");
    chk_chan_conv_hold: assert property (
        !eoc && !$past(eoc) |-> $stable(channel)) else $error("channel moved in conversion");
endmodule

/* File: bench/asf_host_model.sv */
// Host serial master model: idle-low clock, 16-bit frames
module asf_host_model (
    input wire logic clk,
    output logic cs_n_pin,
    output logic sclk_pin,
    output logic sdi_pin,
    input wire logic sdo,
    input wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock stands still between frames; each level spans six system clocks
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        sdi_pin = 1'b0;
    end

    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, output logic oe_mid);
        rx = 16'h0000;
        oe_mid = 1'b0;
        @(posedge clk) cs_n_pin <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 15; i >= 0; i--) begin
            sclk_pin <= 1'b1;
            sdi_pin <= tx[i];
            repeat (6) @(posedge clk);
            sclk_pin <= 1'b0;
            // A released output reads inverted, so stale data never passes for driven data
            rx[i] = sdo_oe ? sdo : ~sdo;
            if (i == 8) begin
                oe_mid = sdo_oe;
            end
            repeat (6) @(posedge clk);
        end
        cs_n_pin <= 1'b1;
        // Toggle after the frame so a stale bit never passes for a driven one
        sdi_pin <= ~tx[0];
        repeat (8) @(posedge clk);
    endtask
endmodule

/* File: bench/tb_adc_sequencer_fifo_control.sv */
// Testbench for the converter sequencer: modes, FIFO, interrupt, power-down
module tb_adc_sequencer_fifo_control import asf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // The first oscillator tick lands anywhere within one divider period after the start
    localparam int CONV_MAX = CONV_CLKS_14 * OSC_DIV_DEF + CONV_EXTRA_CYC;
    localparam int CONV_MIN = CONV_MAX - OSC_DIV_DEF + 1;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic conv_start_pin_n = 1'b1;
    logic [13:0] adc_result = 14'h0000;
    logic cs_n_pin, sclk_pin, sdi_pin, sdo, sdo_oe, eoc, int_n, power_down, oe_mid;
    logic [2:0] channel, last_ch;
    logic [15:0] rx;
    int num_errors = 0;
    int n_checks = 0;
    int lo_cnt = 0;
    int last_len = 0;

    always #12.5 clk = ~clk;

    asf_seq_ctrl #(.RES_BITS(14)) dut_u (.clk(clk), .rstn(rstn), .cs_n_pin(cs_n_pin), .frame_sync(1'b0),
        .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .conv_start_pin_n(conv_start_pin_n), .adc_result(adc_result),
        .sdo(sdo), .sdo_oe(sdo_oe), .eoc(eoc), .int_n(int_n), .channel(channel), .power_down(power_down));
    asf_host_model host_u (.clk(clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
        .sdo(sdo), .sdo_oe(sdo_oe));

    // Length and channel of the last conversion
    always @(posedge clk) begin
        if (!eoc) begin
            lo_cnt <= lo_cnt + 1;
            last_ch <= channel;
        end else if (lo_cnt != 0) begin
            last_len <= lo_cnt;
            lo_cnt <= 0;
        end
    end

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t mismatch: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic frame(input logic [3:0] cmd, input logic [11:0] data);
        host_u.xfer({cmd, data}, rx, oe_mid);
    endtask

    task automatic conv_wait();
        int t;
        t = 0;
        while (eoc !== 1'b0 && t < 60) begin
            @(posedge clk);
            t++;
        end
        check({15'h0000, t < 60}, 16'h0001);
        while (eoc !== 1'b1 && t < 600) begin
            @(posedge clk);
            t++;
        end
        @(posedge clk);
        check({15'h0000, t < 600}, 16'h0001);
        check({15'h0000, last_len >= CONV_MIN && last_len <= CONV_MAX}, 16'h0001);
        check({15'h0000, power_down}, 16'h0001);
    endtask

    task automatic cfg_write(input logic [11:0] cfg);
        frame(CMD_CFG_WRITE, cfg);
        check({14'h0000, eoc, int_n}, 16'h0003);
    endtask

    // Select frames start one conversion each; interrupt only after the last
    task automatic run(input int n, input logic [2:0] ch0, input logic [2:0] step, input logic [13:0] base,
        input logic after_int);
        for (int k = 0; k < n; k++) begin
            @(posedge clk) adc_result <= base + 14'(k);
            frame(4'h3, 12'h000);
            if (k == 0 && after_int) check({15'h0000, oe_mid}, 16'h0000);
            conv_wait();
            check({13'h0000, last_ch}, {13'h0000, ch0 + 3'(k) * step});
            repeat (4) @(posedge clk);
            check({15'h0000, int_n}, {15'h0000, k != n - 1});
        end
    endtask

    task automatic read(input int n, input logic [13:0] base);
        for (int k = 0; k < n; k++) begin
            frame(CMD_FIFO_READ, 12'h000);
            check(rx, {base + 14'(k), 2'b00});
            check({14'h0000, eoc, int_n}, 16'h0003);
        end
    endtask

    task automatic pulse(input logic [13:0] v);
        @(posedge clk) adc_result <= v;
        conv_start_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        conv_start_pin_n <= 1'b1;
        conv_wait();
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_reset();
        check({9'h000, eoc, int_n, sdo_oe, power_down, channel}, 16'h0060);
    endtask

    task automatic t_shot();
        cfg_write(12'h080);
        run(1, 3'h3, 3'h0, 14'h1ABC, 1'b0);
        @(posedge clk) adc_result <= 14'h0555;
        frame(4'h3, 12'h000);
        check(rx, {14'h1ABC, 2'b00});
        conv_wait();
    endtask

    task automatic t_pin_shot();
        cfg_write(12'h280);
        frame(4'h3, 12'h000);
        check({15'h0000, eoc}, 16'h0001);
        pulse(14'h0111);
        pulse(14'h0222);
        frame(4'h3, 12'h000);
        check(rx, {14'h0222, 2'b00});
    endtask

    // Pin-triggered sweep: a select arms each run, the pin starts each sample
    task automatic t_pin_sweep();
        cfg_write(12'h2CB);
        frame(4'h3, 12'h000);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                repeat (4) @(posedge clk);
                check({15'h0000, int_n}, 16'h0000);
                read(2, 14'h0A00);
                frame(4'h3, 12'h000);
            end
            pulse(14'h0A00 + 14'(k));
            check({13'h0000, last_ch}, {13'h0000, 3'(k % 2) * 3'h2});
        end
    endtask

    task automatic t_fifo_modes();
        cfg_write(12'h0A3);
        run(2, 3'h3, 3'h0, 14'h1100, 1'b0);
        read(2, 14'h1100);
        cfg_write(12'h0E1);
        run(6, 3'h0, 3'h1, 14'h2000, 1'b0);
        // Six entries left behind: the next write must empty the FIFO
        cfg_write(12'h0CA);
        run(4, 3'h0, 3'h2, 14'h2100, 1'b0);
        read(4, 14'h2100);
        run(4, 3'h0, 3'h2, 14'h2200, 1'b0);
        read(2, 14'h2200);
        // Two entries left: the select must drop them and start afresh
        run(4, 3'h0, 3'h2, 14'h2300, 1'b1);
        read(4, 14'h2300);
        cfg_write(12'h0E8);
        run(8, 3'h0, 3'h2, 14'h3000, 1'b0);
        run(8, 3'h0, 3'h2, 14'h3100, 1'b1);
        read(8, 14'h3100);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_shot();
        t_pin_shot();
        t_pin_sweep();
        t_fifo_modes();
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule

bind asf_seq_ctrl asf_seq_chk chk_u (.clk(clk), .rstn(rstn), .cs_n_pin(cs_n_pin), .sdo_oe(sdo_oe), .eoc(eoc),
    .int_n(int_n), .channel(channel), .power_down(power_down));
